// *** rtl/sow_options.sv ***
// Chosen here: register access over Avalon-MM and the address map.
`default_nettype none
// Overview of operation
// - Options one keeps only its first write after each reset.
// - Options one always reads back its current contents.
// - Timeout field bits 7:6 with clock select sets period; 00 disables.
// - Internal: 32/256/1024 ticks; bus: 8192/65536/262144 cycles.
// - Options two bit 7 picks internal 1 kHz (0) or bus clock (1).
// - Options two bit 6 enables windowed watchdog.
// - Windowed: any status write in first three quarters resets.
// - Bus clock window opens at 6144/49152/196608; none on 1 kHz.
// - Stop enable bit 5; when clear a stop instruction forces reset.
// - Bit 4 moves serial two pins from port F to port E.
// - Bit 3 moves two-wire pins from port F to port E.
// - Clock select and window bits accept one write after reset.
// - Options two bit 4 picks ADC trigger: counter overflow or IRQ pin.
// - Divide field bits 2:0 drives clock out when nonzero.
// - Clock out frequency is bus clock over twice the field.
// - Two read-only registers hold the part number, high byte at the lower address.
// - High register also holds revision; writes have no effect.
// - Writing 55 then aa to status address clears watchdog counter.
// - Any other value written there while enabled resets.
// - Counter overflow resets through the watchdog reset request.
module sow_options
    import sow_pkg::*;
#(
    parameter int          LPO_DIV  = SOW_LPO_DIV,
    parameter logic [11:0] PART_NUM = SOW_PART_DEF,
    parameter logic [3:0]  REV_NUM  = SOW_REV_DEF
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        status_write,
    input  wire logic [7:0]  status_wdata,
    input  wire logic        stop_executed,
    output var  logic        watchdog_reset,
    output var  logic        illegal_opcode_reset,
    output var  logic        stop_mode_enable,
    output var  logic        serial_two_pin_select,
    output var  logic        twowire_pin_select,
    output var  logic        adc_trigger_source_select,
    output var  logic        port_a_bit0,
    output var  logic        port_a_bit0_oe
);

    // *********************************************************
    // Bus slave
    // *********************************************************
    logic        opt1_done_q;
    logic        opt2_done_q;
    logic [7:0]  opt1_q;
    logic [7:0]  opt2_q;
    logic        ack_q;
    logic [31:0] rdata_q;

    // Decode; one-cycle wait then ack so every access takes two edges
    wire  acc      = (avs_read | avs_write) & ~ack_q;
    // Writes land at the edge that sees waitrequest low, as the master expects
    wire  wr_lane  = avs_write & avs_byteenable[0] & ack_q;
    wire  hit_opt1 = avs_address == SOW_OFS_OPT1;
    wire  hit_opt2 = avs_address == SOW_OFS_OPT2;
    wire  hit_pnhi = avs_address == SOW_OFS_PNHI;
    wire  hit_pnlo = avs_address == SOW_OFS_PNLO;
    wire  wr_opt1  = wr_lane & hit_opt1 & ~opt1_done_q;
    wire  wr_opt2  = wr_lane & hit_opt2;
    wire  [7:0] pnhi = {REV_NUM, PART_NUM[11:8]};
    wire  [7:0] pnlo = PART_NUM[7:0];
    wire  [7:0] rd_sel = hit_opt1 ? opt1_q :
                         hit_opt2 ? opt2_q :
                         hit_pnhi ? pnhi :
                         hit_pnlo ? pnlo : 8'h00;

    // Answer register: waitrequest falls one edge after the request
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            rdata_q         <= 32'h0000_0000;
        end else begin
            ack_q           <= acc;
            avs_waitrequest <= ~acc;
            rdata_q         <= acc ? {24'h00_0000, rd_sel} : rdata_q;
        end
    end
    assign avs_readdata    = rdata_q;

    // *********************************************************
    // Option registers
    // *********************************************************
    // Options one: whole register locks on its first write
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            opt1_q      <= SOW_OPT1_RST;
            opt1_done_q <= 1'b0;
        end else if (wr_opt1) begin
            opt1_q      <= avs_writedata[7:0] & SOW_OPT1_MASK;
            opt1_done_q <= 1'b1;
        end
    end

    // Options two: watchdog bits lock, trigger and divide stay free
    wire [7:0] opt2_once = wr_opt2 & ~opt2_done_q ? avs_writedata[7:0] : opt2_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            opt2_q      <= SOW_OPT2_RST;
            opt2_done_q <= 1'b0;
        end else if (wr_opt2) begin
            opt2_q      <= {opt2_once[7:6], 1'b0, avs_writedata[4], 1'b0,
                            avs_writedata[2:0]};
            opt2_done_q <= 1'b1;
        end
    end

    wire [1:0] to_sel  = opt1_q[SOW_TO_HI:SOW_TO_LO];
    wire       clk_sel = opt2_q[SOW_CLKS_B];
    wire       win_en  = opt2_q[SOW_WIN_B] & clk_sel;
    wire [2:0] div_sel = opt2_q[2:0];

    // Option bits registered on their way to the pin muxes, stop control and ADC trigger select
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stop_mode_enable          <= 1'b0;
            serial_two_pin_select     <= 1'b0;
            twowire_pin_select        <= 1'b0;
            adc_trigger_source_select <= 1'b0;
        end else begin
            stop_mode_enable          <= opt1_q[SOW_STOP_MODE_ENABLE_B];
            serial_two_pin_select     <= opt1_q[SOW_SER2_B];
            twowire_pin_select        <= opt1_q[SOW_TWI_B];
            adc_trigger_source_select <= opt2_q[SOW_ADTS_B];
        end
    end

    // *********************************************************
    // Watchdog
    // *********************************************************
    logic [15:0] lpo_cnt_q;
    logic [18:0] wd_cnt_q;
    logic        svc_armed_q;

    // Internal 1 kHz tick derived from the bus clock
    wire lpo_tick = lpo_cnt_q == 16'(LPO_DIV - 1);
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            lpo_cnt_q <= 16'h0000;
        end else begin
            lpo_cnt_q <= lpo_tick ? 16'h0000 : lpo_cnt_q + 16'h0001;
        end
    end

    // Period and window lookups
    wire        wd_en = to_sel != 2'b00;
    wire [18:0] ovf   = clk_sel ?
                        (to_sel == 2'b01 ? SOW_BUS_OVF1 :
                         to_sel == 2'b10 ? SOW_BUS_OVF2 : SOW_BUS_OVF3) :
                        (to_sel == 2'b01 ? {1'b0, SOW_LPO_OVF1} :
                         to_sel == 2'b10 ? {1'b0, SOW_LPO_OVF2} :
                         {1'b0, SOW_LPO_OVF3});
    wire [18:0] wopen = to_sel == 2'b01 ? SOW_WIN_OPEN1 :
                        to_sel == 2'b10 ? SOW_WIN_OPEN2 : SOW_WIN_OPEN3;
    wire        step  = clk_sel | lpo_tick;
    wire        wd_ovf = wd_en & step & (wd_cnt_q == ovf - 19'd1);
    wire        st_wr  = status_write & wd_en;
    wire        early  = win_en & (wd_cnt_q < wopen);
    wire        bad_v  = st_wr & (status_wdata != SOW_SVC_FIRST) &
                         (status_wdata != SOW_SVC_SECOND);
    wire        svc    = st_wr & svc_armed_q & ~early &
                         (status_wdata == SOW_SVC_SECOND);
    wire        bad    = bad_v | (st_wr & early);

    // Counter with sequence tracking; a stray 55 rearms the sequence
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wd_cnt_q    <= 19'h0_0000;
            svc_armed_q <= 1'b0;
        end else begin
            if (!wd_en || svc || wd_ovf) begin
                wd_cnt_q <= 19'h0_0000;
            end else if (step) begin
                wd_cnt_q <= wd_cnt_q + 19'd1;
            end
            if (st_wr) begin
                svc_armed_q <= status_wdata == SOW_SVC_FIRST;
            end
        end
    end

    // Reset requests, one-cycle pulses to the reset controller
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            watchdog_reset       <= 1'b0;
            illegal_opcode_reset <= 1'b0;
        end else begin
            watchdog_reset       <= wd_ovf | bad;
            illegal_opcode_reset <= stop_executed & ~opt1_q[SOW_STOP_MODE_ENABLE_B];
        end
    end

    // *********************************************************
    // Clock output divider
    // *********************************************************
    logic [2:0] div_cnt_q;

    // Toggle every field-value cycles gives bus over twice the field
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            div_cnt_q      <= 3'h0;
            port_a_bit0    <= 1'b0;
            port_a_bit0_oe <= 1'b0;
        end else begin
            port_a_bit0_oe <= div_sel != 3'h0;
            if (div_sel == 3'h0) begin
                div_cnt_q   <= 3'h0;
                port_a_bit0 <= 1'b0;
            end else if (div_cnt_q >= div_sel - 3'h1) begin
                div_cnt_q   <= 3'h0;
                port_a_bit0 <= ~port_a_bit0;
            end else begin
                div_cnt_q   <= div_cnt_q + 3'h1;
            end
        end
    end

    // *********************************************************
    // Checks
    // *********************************************************
    property p_opt1_lock;
        @(posedge clock) disable iff (!reset_n)
        opt1_done_q |=> $stable(opt1_q);
    endproperty
    a_opt1_lock: assert property (p_opt1_lock) else $error("opt1 changed after lock");

    property p_read_opt1;
        @(posedge clock) disable iff (!reset_n)
        (acc & avs_read & hit_opt1) |=> (avs_readdata[7:0] == $past(opt1_q));
    endproperty
    a_read_opt1: assert property (p_read_opt1) else $error("opt1 readback wrong");

    property p_wd_off;
        @(posedge clock) disable iff (!reset_n)
        (to_sel == 2'b00) |=> !watchdog_reset;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("reset while disabled");

    property p_wd_lock;
        @(posedge clock) disable iff (!reset_n)
        opt2_done_q |=> $stable(opt2_q[7:6]);
    endproperty
    a_wd_lock: assert property (p_wd_lock) else $error("watchdog bits changed");

    property p_bad_value;
        @(posedge clock) disable iff (!reset_n)
        (status_write & wd_en & (status_wdata == 8'h12)) |=> watchdog_reset;
    endproperty
    a_bad_value: assert property (p_bad_value) else $error("bad value no reset");

    property p_early;
        @(posedge clock) disable iff (!reset_n)
        (status_write & wd_en & win_en & (wd_cnt_q < wopen)) |=> watchdog_reset;
    endproperty
    a_early: assert property (p_early) else $error("early write no reset");

    property p_service;
        @(posedge clock) disable iff (!reset_n)
        svc |=> (wd_cnt_q == 19'h0_0000) && !watchdog_reset;
    endproperty
    a_service: assert property (p_service) else $error("service not cleared");

    property p_overflow;
        @(posedge clock) disable iff (!reset_n)
        (wd_en & clk_sel & (wd_cnt_q == ovf - 19'd1)) |=> watchdog_reset;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow no reset");

    property p_stop;
        @(posedge clock) disable iff (!reset_n)
        (stop_executed & !opt1_q[SOW_STOP_MODE_ENABLE_B]) |=> illegal_opcode_reset;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not trapped");

    property p_clkout_en;
        @(posedge clock) disable iff (!reset_n)
        (div_sel == 3'h0) |=> !port_a_bit0_oe;
    endproperty
    a_clkout_en: assert property (p_clkout_en) else $error("clock out not off");

endmodule : sow_options
`default_nettype wire

// *** inc/sow_pkg.sv ***
`default_nettype none
// *********************************************************
// Shared constants of the options and watchdog bank
// *********************************************************
package sow_pkg;
    // Register byte addresses on the word-wide bus
    localparam logic [3:0] SOW_OFS_OPT1    = 4'h0;
    localparam logic [3:0] SOW_OFS_OPT2    = 4'h4;
    localparam logic [3:0] SOW_OFS_PNHI    = 4'h8;
    localparam logic [3:0] SOW_OFS_PNLO    = 4'hc;
    localparam logic [3:0] SOW_OFS_RSTSTAT = 4'h0; // Index of service port word on its own bus
    // Reset values
    localparam logic [7:0] SOW_OPT1_RST    = 8'hc0;
    localparam logic [7:0] SOW_OPT2_RST    = 8'h00;
    // Writable masks
    localparam logic [7:0] SOW_OPT1_MASK   = 8'hf8;
    localparam logic [7:0] SOW_OPT2_MASK   = 8'hd7;
    // Field positions
    localparam int SOW_TO_HI   = 7;
    localparam int SOW_TO_LO   = 6;
    localparam int SOW_STOP_MODE_ENABLE_B = 5;
    localparam int SOW_SER2_B  = 4;
    localparam int SOW_TWI_B   = 3;
    localparam int SOW_CLKS_B  = 7;
    localparam int SOW_WIN_B   = 6;
    localparam int SOW_ADTS_B  = 4;
    // Watchdog service values
    localparam logic [7:0] SOW_SVC_FIRST  = 8'h55;
    localparam logic [7:0] SOW_SVC_SECOND = 8'haa;
    // Overflow counts: internal 1 kHz clock, then bus clock
    localparam logic [17:0] SOW_LPO_OVF1 = 18'd32;
    localparam logic [17:0] SOW_LPO_OVF2 = 18'd256;
    localparam logic [17:0] SOW_LPO_OVF3 = 18'd1024;
    localparam logic [18:0] SOW_BUS_OVF1 = 19'd8192;
    localparam logic [18:0] SOW_BUS_OVF2 = 19'd65536;
    localparam logic [18:0] SOW_BUS_OVF3 = 19'd262144;
    // Window opening counts on the bus clock
    localparam logic [18:0] SOW_WIN_OPEN1 = 19'd6144;
    localparam logic [18:0] SOW_WIN_OPEN2 = 19'd49152;
    localparam logic [18:0] SOW_WIN_OPEN3 = 19'd196608;
    // Internal 1 kHz tick period in bus clocks at 40 MHz
    localparam int SOW_CLK_HZ   = 40000000;
    localparam int SOW_LPO_HZ   = 1000;
    localparam int SOW_LPO_DIV  = SOW_CLK_HZ / SOW_LPO_HZ;
    // Identification, values arbitrary
    localparam logic [11:0] SOW_PART_DEF = 12'h5a3;
    localparam logic [3:0]  SOW_REV_DEF  = 4'h1;
endpackage : sow_pkg
`default_nettype wire

// *** verif/sow_options_test.sv ***
`default_nettype none
// ************************************************************
// Bench for the options and watchdog bank
// ************************************************************
module sow_options_test
    import sow_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] TB_PART = 12'h3c5; // Arbitrary part number
    localparam logic [3:0]  TB_REV  = 4'h2;    // Arbitrary revision
    logic        clock = 1'b0;
    logic        reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        status_write, stop_executed, watchdog_reset, illegal_opcode_reset;
    logic [7:0]  status_wdata;
    logic        stop_mode_enable, serial_two_pin_select, twowire_pin_select;
    logic        adc_trigger_source_select, port_a_bit0, port_a_bit0_oe;
    int          checks, miscompares, cyc, rel, wdr_cnt, wdr_at, ill_cnt, per, t;

    // Short internal tick makes the 1 kHz timeouts 128, 1024 and 4096 cycles
    sow_options #(.LPO_DIV(4), .PART_NUM(TB_PART), .REV_NUM(TB_REV)) uut (
        .clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .status_write(status_write),
        .status_wdata(status_wdata), .stop_executed(stop_executed),
        .watchdog_reset(watchdog_reset), .illegal_opcode_reset(illegal_opcode_reset),
        .stop_mode_enable(stop_mode_enable), .serial_two_pin_select(serial_two_pin_select),
        .twowire_pin_select(twowire_pin_select),
        .adc_trigger_source_select(adc_trigger_source_select),
        .port_a_bit0(port_a_bit0), .port_a_bit0_oe(port_a_bit0_oe));

    // 40 MHz clock
    always #12.5 clock = ~clock;

    // Cycle count and reset pulse tallies
    always @(posedge clock) begin
        cyc++;
        if (watchdog_reset === 1'b1) begin
            wdr_cnt++;
            wdr_at = cyc;
        end
        if (illegal_opcode_reset === 1'b1) ill_cnt++;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task do_reset;
        reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rel = cyc;
        wdr_cnt = 0;
        ill_cnt = 0;
    endtask : do_reset

    // Request held until waitrequest is seen low, then released
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        if (n >= 20) begin
            miscompares++;
            $display("BAD %0t: bus access never answered", $time);
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clock);
    endtask : bus

    task rdchk(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd, {24'h0, exp});
    endtask : rdchk

    task svc(input logic [7:0] d);
        status_wdata <= d;
        status_write <= 1'b1;
        @(posedge clock);
        status_write <= 1'b0;
        @(posedge clock);
    endtask : svc

    // Cycles between two rising edges of the divided clock
    task measure;
        int  i, t0;
        logic prev;
        t0 = -1;
        per = -1;
        prev = port_a_bit0;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            if (port_a_bit0 === 1'b1 && prev === 1'b0) begin
                if (t0 < 0) t0 = i;
                else if (per < 0) per = i - t0;
            end
            prev = port_a_bit0;
        end
    endtask : measure

    // Hang guard, well beyond the longest watchdog run
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        summarize;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        reset_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
        avs_writedata = 32'h0; avs_byteenable = 4'hf; status_write = 1'b0;
        status_wdata = 8'h00; stop_executed = 1'b0;
        do_reset;
        rdchk(SOW_OFS_OPT1, SOW_OPT1_RST);
        rdchk(SOW_OFS_OPT2, SOW_OPT2_RST);
        bus(1'b1, SOW_OFS_PNLO, 8'hff); // Identification must not change
        bus(1'b1, SOW_OFS_PNHI, 8'h00);
        rdchk(SOW_OFS_PNLO, TB_PART[7:0]);
        rdchk(SOW_OFS_PNHI, {TB_REV, TB_PART[11:8]});
        rdchk(4'h2, 8'h00);
        // Watchdog off, every pin option set, reserved bits poked
        bus(1'b1, SOW_OFS_OPT1, 8'h3f);
        rdchk(SOW_OFS_OPT1, 8'h3f & SOW_OPT1_MASK);
        bus(1'b1, SOW_OFS_OPT1, 8'hc0);
        rdchk(SOW_OFS_OPT1, 8'h38);
        check(stop_mode_enable, 1);
        check(serial_two_pin_select, 1);
        check(twowire_pin_select, 1);
        bus(1'b1, SOW_OFS_OPT2, 8'hff);
        rdchk(SOW_OFS_OPT2, 8'hff & SOW_OPT2_MASK);
        check(adc_trigger_source_select, 1);
        bus(1'b1, SOW_OFS_OPT2, 8'h01);
        rdchk(SOW_OFS_OPT2, 8'hc1);
        check(adc_trigger_source_select, 0);
        measure;
        check(per, 2);
        check(port_a_bit0_oe, 1);
        bus(1'b1, SOW_OFS_OPT2, 8'h07);
        measure;
        check(per, 14);
        bus(1'b1, SOW_OFS_OPT2, 8'h00);
        repeat (4) @(posedge clock);
        check(port_a_bit0_oe, 0);
        stop_executed <= 1'b1;
        @(posedge clock);
        stop_executed <= 1'b0;
        svc(8'h12);
        repeat (4) @(posedge clock);
        check(ill_cnt, 0);
        check(wdr_cnt, 0);
        // Stop is refused with the reset default
        do_reset;
        stop_executed <= 1'b1;
        @(posedge clock);
        stop_executed <= 1'b0;
        repeat (3) @(posedge clock);
        check(ill_cnt, 1);
        // Unserviced overflow, internal clock, shortest code
        do_reset;
        bus(1'b1, SOW_OFS_OPT1, 8'h40);
        bus(1'b1, SOW_OFS_OPT2, 8'h00);
        while (wdr_cnt == 0 && cyc - rel < 400) @(posedge clock);
        check(wdr_cnt, 1);
        check(32'(wdr_at - rel >= 124 && wdr_at - rel <= 140), 1);
        // Regular servicing holds it off; a stray value fires it
        do_reset;
        bus(1'b1, SOW_OFS_OPT1, 8'h40);
        bus(1'b1, SOW_OFS_OPT2, 8'h00);
        repeat (4) begin
            repeat (90) @(posedge clock);
            svc(SOW_SVC_FIRST);
            svc(SOW_SVC_SECOND);
        end
        check(wdr_cnt, 0);
        svc(8'h12);
        repeat (3) @(posedge clock);
        check(wdr_cnt, 1);
        // Windowed on bus clock: just before the window opens
        do_reset;
        bus(1'b1, SOW_OFS_OPT1, 8'h40);
        bus(1'b1, SOW_OFS_OPT2, 8'hc0);
        while (cyc - rel < 6000) @(posedge clock);
        svc(SOW_SVC_FIRST);
        repeat (2) @(posedge clock);
        check(wdr_cnt, 1);
        // Windowed on bus clock: service inside the final quarter
        do_reset;
        bus(1'b1, SOW_OFS_OPT1, 8'h40);
        bus(1'b1, SOW_OFS_OPT2, 8'hc0);
        while (cyc - rel < 6300) @(posedge clock);
        svc(SOW_SVC_FIRST);
        svc(SOW_SVC_SECOND);
        t = cyc;
        repeat (2000) @(posedge clock);
        check(wdr_cnt, 0);
        while (wdr_cnt == 0 && cyc - t < 8400) @(posedge clock);
        check(wdr_cnt, 1);
        check(32'(wdr_at - t >= 8170 && wdr_at - t <= 8210), 1);
        summarize;
    end
endmodule : sow_options_test
`default_nettype wire
